// file: rtl/ibs_pkg.sv
// Package for the two-wire bus status flag block: register map, field positions,
// reset values and the packed structs that carry the block's state.
// Assumes a 32-bit APB register bus with byte addresses.
`default_nettype none

package ibs_pkg;

    // Register byte offsets.
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] STATUS_OFS = 8'h04;
    localparam logic [7:0] INT_STAT_OFS = 8'h08;
    localparam logic [7:0] INT_MASK_OFS = 8'h0C;

    // Control register fields.
    localparam int CTRL_ON_BIT = 0;
    localparam int CTRL_MASTER_BIT = 1;
    localparam int CTRL_LEAVE_BIT = 2;
    localparam int CTRL_WAIT_FREE_BIT = 3;

    // Bus status register fields.
    localparam int STAT_STOP_BIT = 0;
    localparam int STAT_START_BIT = 1;
    localparam int STAT_ACK_BIT = 2;
    localparam int STAT_TRC_BIT = 3;

    // Interrupt status and mask fields share one layout.
    localparam int INT_START_BIT = 0;
    localparam int INT_STOP_BIT = 1;
    localparam int INT_ACK_BIT = 2;
    localparam int INT_W = 3;

    // Serial clock counting within a byte.
    localparam logic [3:0] CLK_FIRST = 4'h1;
    localparam logic [3:0] CLK_DIR = 4'h8;
    localparam logic [3:0] CLK_ACK = 4'h9;

    // Reset values.
    localparam logic [1:0] CTRL_RST = 2'h0;
    localparam logic [INT_W-1:0] INT_RST = 3'h0;
    localparam logic [31:0] RDATA_RST = 32'h0000_0000;

    // The four software-visible status flags.
    typedef struct packed {
        logic trc;
        logic ack;
        logic start;
        logic stop;
    } ibs_flags_s;

    // Complete state of the block.
    typedef struct packed {
        logic [1:0] scl_sync;
        logic [1:0] sda_sync;
        logic scl_prev;
        logic sda_prev;
        logic [3:0] clk_cnt;
        logic first_byte;
        logic drive_armed;
        logic arb_prev;
        logic [1:0] ctrl;
        ibs_flags_s flags;
        logic [INT_W-1:0] int_stat;
        logic [INT_W-1:0] int_mask;
        logic irq;
        logic sda_out;
        logic sda_oe_n;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } ibs_state_s;

endpackage

`default_nettype wire

// file: rtl/ibs_bus_status.sv
// Status flag logic of a two-wire serial bus controller, reached over APB.
// Assumes the serial pins arrive unsynchronised, and that the start generator,
// shift-out latch and arbitration flag come from logic on sys_clk.
// Assumes both lines idle high through pull-ups, so the pin stages reset to one.
//
// Summary of operation
// - Transmit flag drives shift latch from ninth clock, or from start generation in master mode
// - Receive status leaves data line released
// - Master start generation sets transmit flag
// - Master sending direction zero sets transmit flag
// - Master sending direction one clears transmit flag
// - Slave receiving direction one sets transmit flag
// - Stop, leave, disable, wait free, arbitration clear transmit
// - Wait release at ninth clock releases data line
// - Low data at ninth clock rise sets ack
// - Stop, next byte, leave, disable clear ack
// - Start condition sets start flag
// - Stop, byte after address, leave, disable clear start
// - Stop condition sets stop flag
// - Stop flag clears at address byte first clock
// - Controller turning off clears stop flag
`default_nettype none

module ibs_bus_status (
    input wire logic sys_clk,
    input wire logic reset,
    // APB slave.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Serial pins, data pin split into input, output and enable.
    input wire logic serial_clock_pin,
    input wire logic serial_data_pin_in,
    output logic serial_data_pin_out,
    output logic serial_data_pin_oe_n,
    // Same-clock inputs from the rest of the controller.
    input wire logic start_generated,
    input wire logic shift_out_bit,
    input wire logic arb_lost_flag,
    // Status and interrupt outputs.
    output logic [3:0] bus_status_register,
    output logic irq
);

    // Registered state and its next value.
    ibs_pkg::ibs_state_s state_reg;
    ibs_pkg::ibs_state_s state_next;

    // Bus-side decode helpers.
    logic setup_phase;
    logic wr_done;
    logic controller_on;
    logic master_mode;
    logic leave_comm_request;
    logic wait_free_request;
    logic controller_off_edge;

    // Serial line events seen on the second synchroniser stage.
    logic scl_now;
    logic sda_now;
    logic scl_rise;
    logic start_evt;
    logic stop_evt;
    logic [3:0] clk_inc;
    logic arb_rise;

    // Line events are derived from the second synchroniser stage only.
    // A third stage holds the previous settled level, so an edge is reported only
    // in the one cycle in which the second stage differs from it. A start is a data fall while the clock stays high,
    // and a stop is a data rise while the clock stays high.
    always_comb begin
        scl_now = state_reg.scl_sync[1];
        sda_now = state_reg.sda_sync[1];
        scl_rise = scl_now & ~state_reg.scl_prev;
        start_evt = scl_now & state_reg.scl_prev & state_reg.sda_prev & ~sda_now;
        stop_evt = scl_now & state_reg.scl_prev & ~state_reg.sda_prev & sda_now;
        clk_inc = state_reg.clk_cnt + 4'h1;
        arb_rise = arb_lost_flag & ~state_reg.arb_prev;
    end

    // A write takes effect only in the access cycle in which pready is high.
    // The slave answers in the cycle after setup with no wait states, so a write is
    // applied at the one edge at which the master sees pready high. The leave and
    // wait-release bits are write-only pulses that last for that single cycle.
    always_comb begin
        setup_phase = psel & ~penable;
        wr_done = psel & penable & state_reg.pready & pwrite;
        controller_on = state_reg.ctrl[ibs_pkg::CTRL_ON_BIT];
        master_mode = state_reg.ctrl[ibs_pkg::CTRL_MASTER_BIT];
        leave_comm_request = 1'b0;
        wait_free_request = 1'b0;
        controller_off_edge = 1'b0;
        if (wr_done && paddr == ibs_pkg::CTRL_OFS) begin
            leave_comm_request = pwdata[ibs_pkg::CTRL_LEAVE_BIT];
            wait_free_request = pwdata[ibs_pkg::CTRL_WAIT_FREE_BIT];
            controller_off_edge = controller_on & ~pwdata[ibs_pkg::CTRL_ON_BIT];
        end
    end

    // Next-state logic for the whole block.
    // Every field keeps its value unless a branch below changes it. The order of the
    // branches matters: clears come before sets, and the disable branch comes last so
    // that a stopped controller always reports all four flags as zero.
    always_comb begin
        state_next = state_reg;

        // Two flip-flops on each pin, then one more stage for edge finding.
        state_next.scl_sync = {state_reg.scl_sync[0], serial_clock_pin};
        state_next.sda_sync = {state_reg.sda_sync[0], serial_data_pin_in};
        state_next.scl_prev = scl_now;
        state_next.sda_prev = sda_now;
        state_next.arb_prev = arb_lost_flag;

        // Byte clock counting: a start restarts the address byte.
        // The counter holds the number of clock rises seen in the current byte. It
        // restarts at zero on a start, so the address byte counts one to nine, and
        // every later byte runs from one to nine again, its first clock wrapping nine to one.
        if (start_evt) begin
            state_next.clk_cnt = 4'h0;
            state_next.first_byte = 1'b1;
        end else if (scl_rise) begin
            if (state_reg.clk_cnt == ibs_pkg::CLK_ACK) begin
                state_next.clk_cnt = ibs_pkg::CLK_FIRST;
                state_next.first_byte = 1'b0;
            end else begin
                state_next.clk_cnt = clk_inc;
            end
        end

        // Flag clears first, so that any set in the same cycle wins.
        // A repeated start needs no special case: the start branch above rewinds
        // the counter and marks the address byte again.
        if (stop_evt) begin
            state_next.flags.trc = 1'b0;
            state_next.flags.ack = 1'b0;
            state_next.flags.start = 1'b0;
            state_next.drive_armed = 1'b0;
        end
        if (leave_comm_request) begin
            state_next.flags.trc = 1'b0;
            state_next.flags.ack = 1'b0;
            state_next.flags.start = 1'b0;
        end
        if (arb_rise) begin
            state_next.flags.trc = 1'b0;
        end
        // Wait release at the ninth clock drops transmit and the data line.
        if (wait_free_request) begin
            state_next.flags.trc = 1'b0;
            state_next.drive_armed = 1'b0;
        end
        if (scl_rise && !start_evt) begin
            if (state_reg.clk_cnt == ibs_pkg::CLK_ACK) begin
                // The next byte's first clock ends the previous acknowledge.
                state_next.flags.ack = 1'b0;
                if (state_reg.first_byte) begin
                    state_next.flags.start = 1'b0;
                end
            end
            if (state_reg.clk_cnt == 4'h0 && state_reg.first_byte) begin
                state_next.flags.stop = 1'b0;
            end
        end

        // Sets from bus events.
        // The direction bit is the eighth bit of the address byte, so it is taken
        // on the eighth rise; the acknowledge is taken on the ninth.
        if (start_evt) begin
            state_next.flags.start = 1'b1;
        end
        if (stop_evt) begin
            state_next.flags.stop = 1'b1;
        end
        if (scl_rise && state_reg.clk_cnt == (ibs_pkg::CLK_DIR - 4'h1)) begin
            // The eighth rise samples the direction bit of the first byte.
            if (state_reg.first_byte && master_mode) begin
                state_next.flags.trc = ~sda_now;
            end else if (state_reg.first_byte && sda_now) begin
                state_next.flags.trc = 1'b1;
            end
        end
        if (scl_rise && state_reg.clk_cnt == (ibs_pkg::CLK_ACK - 4'h1)) begin
            if (!sda_now) begin
                state_next.flags.ack = 1'b1;
            end
            if (state_reg.first_byte) begin
                state_next.drive_armed = 1'b1;
            end
        end
        if (start_generated && master_mode) begin
            state_next.flags.trc = 1'b1;
            state_next.drive_armed = 1'b1;
        end

        // Turning the controller off clears every flag and the counter.
        // Holding the flags at zero while off also covers the falling edge of the
        // enable, and keeps stale line events from showing when it is turned on.
        if (!controller_on || controller_off_edge) begin
            state_next.flags = '0;
            state_next.drive_armed = 1'b0;
            state_next.clk_cnt = 4'h0;
            state_next.first_byte = 1'b0;
        end

        // Data pin: drive the shift latch only in transmit status.
        // The enable is low only while the block transmits, so a receiver never
        // fights another party on the data line.
        if (state_next.flags.trc && state_next.drive_armed) begin
            state_next.sda_out = shift_out_bit;
            state_next.sda_oe_n = 1'b0;
        end else begin
            state_next.sda_out = 1'b1;
            state_next.sda_oe_n = 1'b1;
        end

        // Interrupt status: events set, written ones clear, set wins.
        // An event in the same cycle as a clearing write sets its bit again, so no
        // event is lost to a clear that races it.
        state_next.int_stat[ibs_pkg::INT_START_BIT] = state_reg.int_stat[ibs_pkg::INT_START_BIT];
        if (wr_done && paddr == ibs_pkg::INT_STAT_OFS) begin
            state_next.int_stat = state_reg.int_stat & ~pwdata[ibs_pkg::INT_W-1:0];
        end
        if (controller_on) begin
            if (start_evt) begin
                state_next.int_stat[ibs_pkg::INT_START_BIT] = 1'b1;
            end
            if (stop_evt) begin
                state_next.int_stat[ibs_pkg::INT_STOP_BIT] = 1'b1;
            end
            if (scl_rise && !sda_now && state_reg.clk_cnt == (ibs_pkg::CLK_ACK - 4'h1)) begin
                state_next.int_stat[ibs_pkg::INT_ACK_BIT] = 1'b1;
            end
        end
        state_next.irq = |(state_next.int_stat & state_next.int_mask);

        // Register writes; the status register ignores writes.
        // Only the enable and mode bits are stored; the request bits act at once.
        if (wr_done) begin
            if (paddr == ibs_pkg::CTRL_OFS) begin
                state_next.ctrl = pwdata[1:0];
            end else if (paddr == ibs_pkg::INT_MASK_OFS) begin
                state_next.int_mask = pwdata[ibs_pkg::INT_W-1:0];
            end
        end

        // APB answer: ready and data are prepared in the setup cycle.
        // Unmapped addresses answer with an error and read as zero; the status word
        // is built straight from the flags and cannot be written.
        state_next.pready = setup_phase;
        state_next.pslverr = 1'b0;
        state_next.prdata = ibs_pkg::RDATA_RST;
        if (setup_phase) begin
            if (paddr == ibs_pkg::CTRL_OFS) begin
                state_next.prdata = {30'h0000_0000, state_reg.ctrl};
            end else if (paddr == ibs_pkg::STATUS_OFS) begin
                state_next.prdata = {28'h000_0000, state_reg.flags};
            end else if (paddr == ibs_pkg::INT_STAT_OFS) begin
                state_next.prdata = {29'h0000_0000, state_reg.int_stat};
            end else if (paddr == ibs_pkg::INT_MASK_OFS) begin
                state_next.prdata = {29'h0000_0000, state_reg.int_mask};
            end else begin
                state_next.pslverr = 1'b1;
            end
        end
    end

    // State register with synchronous reset.
    // The pin stages reset to one, the idle level of both lines, so that no false
    // edge is reported in the first cycles after reset.
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            state_reg <= '0;
            state_reg.scl_sync <= 2'h3;
            state_reg.sda_sync <= 2'h3;
            state_reg.scl_prev <= 1'b1;
            state_reg.sda_prev <= 1'b1;
            state_reg.ctrl <= ibs_pkg::CTRL_RST;
            state_reg.int_stat <= ibs_pkg::INT_RST;
            state_reg.int_mask <= ibs_pkg::INT_RST;
            state_reg.sda_out <= 1'b1;
            state_reg.sda_oe_n <= 1'b1;
            state_reg.prdata <= ibs_pkg::RDATA_RST;
        end else begin
            state_reg <= state_next;
        end
    end

    // Outputs come straight from the state register.
    // No output passes through logic after the register, so every pin and bus
    // output changes only at a clock edge.
    assign prdata = state_reg.prdata;
    assign pready = state_reg.pready;
    assign pslverr = state_reg.pslverr;
    assign serial_data_pin_out = state_reg.sda_out;
    assign serial_data_pin_oe_n = state_reg.sda_oe_n;
    assign bus_status_register = state_reg.flags;
    assign irq = state_reg.irq;

endmodule

`default_nettype wire

// file: dv/ibs_bus_monitor.sv
// Checker for the bus status block, watching its ports only.
// Assumes it is bound into every instance of ibs_bus_status.
`default_nettype none
module ibs_bus_monitor (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic serial_data_pin_in,
    input wire logic serial_data_pin_out,
    input wire logic serial_data_pin_oe_n,
    input wire logic shift_out_bit,
    input wire logic arb_lost_flag,
    input wire logic [3:0] bus_status_register
);
    timeunit 1ns;
    timeprecision 1ps;
    // All checks run on the block clock and rest during reset.
    default clocking @(posedge sys_clk); endclocking
    default disable iff (reset);
    // A setup cycle of the register bus.
    sequence s_setup;
        psel && !penable;
    endsequence
    // A completed write to the status register.
    sequence s_stat_wr;
        psel && penable && pready && pwrite && paddr == ibs_pkg::STATUS_OFS;
    endsequence
    property p_ready;
        s_setup |=> pready ##1 !pready;
    endproperty
    property p_serr;
        pready && pslverr |-> prdata == 32'h0000_0000;
    endproperty
    property p_ro;
        s_stat_wr |=> $stable(bus_status_register);
    endproperty
    property p_drive;
        !serial_data_pin_oe_n |-> serial_data_pin_out == $past(shift_out_bit);
    endproperty
    property p_recv;
        !bus_status_register[3] && !$past(bus_status_register[3]) |-> serial_data_pin_oe_n;
    endproperty
    property p_arb;
        $rose(arb_lost_flag) |-> ##[1:3] !bus_status_register[3];
    endproperty
    property p_ack;
        $rose(bus_status_register[2]) |-> !$past(serial_data_pin_in, 4);
    endproperty
    property p_stop;
        $rose(bus_status_register[0]) |-> bus_status_register[3:1] == 3'h0;
    endproperty
    a_ready: assert property (p_ready) else $error("pready not one cycle after setup");
    a_serr: assert property (p_serr) else $error("refused access returned data");
    a_ro: assert property (p_ro) else $error("status changed by a write");
    a_drive: assert property (p_drive) else $error("data line not shift latch");
    a_recv: assert property (p_recv) else $error("data line driven in receive");
    a_arb: assert property (p_arb) else $error("transmit kept after lost arbitration");
    a_ack: assert property (p_ack) else $error("ack set without low data");
    a_stop: assert property (p_stop) else $error("flags kept at stop");
endmodule
bind ibs_bus_status ibs_bus_monitor mon (.sys_clk, .reset, .psel, .penable, .pwrite, .paddr,
    .prdata, .pready, .pslverr, .serial_data_pin_in, .serial_data_pin_out, .serial_data_pin_oe_n,
    .shift_out_bit, .arb_lost_flag, .bus_status_register);
`default_nettype wire

// file: dv/ibs_line_model.sv
// Another party on the two-wire bus: makes the clock and pulls data low.
// Assumes pull-ups on both lines and an open-drain data output on the block.
`default_nettype none
module ibs_line_model (
    input wire logic sys_clk,
    input wire logic dut_out,
    input wire logic dut_oe_n,
    output logic scl,
    output logic sda
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam real Q = 31.25; // Quarter of the 125 ns link clock.
    logic pull_low = 1'b0; // High while this party pulls data low.
    // Wired-and with pull-up, so a released line reads high.
    assign sda = !pull_low && (dut_oe_n || dut_out);
    initial scl = 1'b1; // The clock stands high between frames.
    // Data falls with the clock high.
    task automatic start();
        @(posedge sys_clk);
        #2;
        pull_low = 1'b1;
        #(Q);
        scl = 1'b0;
        #(Q);
    endtask
    // One clock with the data set up while the clock is low.
    task automatic put_bit(input logic b);
        pull_low = !b;
        #(Q);
        scl = 1'b1;
        #(2 * Q);
        scl = 1'b0;
        #(Q);
    endtask
    // Eight bits first MSB, then the ninth clock with or without ack.
    task automatic send_byte(input logic [7:0] b, input logic ack);
        for (int i = 7; i >= 0; i--) begin
            put_bit(b[i]);
        end
        put_bit(!ack);
    endtask
    // Data rises with the clock high.
    task automatic stop();
        pull_low = 1'b1;
        #(Q);
        scl = 1'b1;
        #(Q);
        pull_low = 1'b0;
        #(2 * Q);
    endtask
endmodule
`default_nettype wire

// file: dv/ibs_bus_status_test.sv
// Self-checking bench for the bus status block.
// Assumes the line model stands for the other parties on the bus.
`default_nettype none
module ibs_bus_status_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk = 1'b0;
    logic reset = 1'b1;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000, prdata, rd_data;
    logic pready, pslverr, rd_err, scl, sda, sda_out, sda_oe_n, irq;
    logic start_gen = 1'b0, shift_bit = 1'b1, arb_lost = 1'b0;
    logic [3:0] status;
    int failures = 0, check_count = 0;
    // One row: master mode, address byte, ack, flags expected after it.
    typedef struct packed {logic m; logic [7:0] b; logic a; logic [3:0] f;} ibs_row_s;
    ibs_row_s rows [5] = '{'{1'b0, 8'hA1, 1'b1, 4'hE}, '{1'b0, 8'hA0, 1'b1, 4'h6},
        '{1'b0, 8'hA1, 1'b0, 4'hA}, '{1'b1, 8'hA0, 1'b1, 4'hE}, '{1'b1, 8'hA1, 1'b1, 4'h6}};
    always #5 sys_clk = !sys_clk;
    ibs_bus_status uut (.sys_clk(sys_clk), .reset(reset), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .serial_clock_pin(scl), .serial_data_pin_in(sda),
        .serial_data_pin_out(sda_out), .serial_data_pin_oe_n(sda_oe_n),
        .start_generated(start_gen), .shift_out_bit(shift_bit), .arb_lost_flag(arb_lost),
        .bus_status_register(status), .irq(irq));
    ibs_line_model lm (.sys_clk(sys_clk), .dut_out(sda_out), .dut_oe_n(sda_oe_n),
        .scl(scl), .sda(sda));
    // Compares one value and counts it.
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
            failures++;
        end
    endtask
    // One register bus transfer; data and error are taken at the ready edge.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do begin
            @(posedge sys_clk);
            n++;
        end while (pready !== 1'b1);
        rd_data = prdata;
        rd_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // The access phase lasts exactly one cycle; the watchdog ends a hang.
        chk(n, 32'h0000_0001);
    endtask
    // Reads a register and compares it.
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        chk(rd_data, exp);
    endtask
    // Prints the counts and the verdict, then stops.
    task automatic end_of_test();
        $display("checks %0d, mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // Cuts a hang short; the tests need under 20 us.
    initial begin
        #500_000;
        failures++;
        end_of_test();
    end
    // Main sequence.
    initial begin
        repeat (10) @(posedge sys_clk);
        reset <= 1'b0;
        rd(ibs_pkg::STATUS_OFS, 32'h0000_0000);
        rd(ibs_pkg::INT_STAT_OFS, 32'h0000_0000);
        rd(8'h10, 32'h0000_0000);
        chk(32'(rd_err), 32'h0000_0001);
        apb(1'b1, ibs_pkg::STATUS_OFS, 32'h0000_000F);
        rd(ibs_pkg::STATUS_OFS, 32'h0000_0000);
        // A masked start event, then unmasked, then cleared.
        apb(1'b1, ibs_pkg::CTRL_OFS, 32'h0000_0001);
        lm.start();
        chk(32'(irq), 32'h0000_0000);
        apb(1'b1, ibs_pkg::INT_MASK_OFS, 32'h0000_0001);
        repeat (2) @(posedge sys_clk);
        chk(32'(irq), 32'h0000_0001);
        rd(ibs_pkg::STATUS_OFS, 32'h0000_0002);
        apb(1'b1, ibs_pkg::INT_STAT_OFS, 32'h0000_0007);
        repeat (2) @(posedge sys_clk);
        chk(32'(irq), 32'h0000_0000);
        lm.stop();
        // Address bytes in both modes, each closed by a stop.
        foreach (rows[i]) begin
            apb(1'b1, ibs_pkg::CTRL_OFS, {30'h0, rows[i].m, 1'b1});
            if (rows[i].m) begin
                start_gen <= 1'b1;
                @(posedge sys_clk);
                start_gen <= 1'b0;
                rd(ibs_pkg::STATUS_OFS, 32'h0000_0009);
            end
            lm.start();
            lm.send_byte(rows[i].b, rows[i].a);
            rd(ibs_pkg::STATUS_OFS, {28'h0, rows[i].f});
            chk(32'(sda_oe_n), 32'(!rows[i].f[3]));
            lm.stop();
            rd(ibs_pkg::STATUS_OFS, 32'h0000_0001);
        end
        apb(1'b1, ibs_pkg::CTRL_OFS, 32'h0000_0000);
        rd(ibs_pkg::STATUS_OFS, 32'h0000_0000);
        // A data byte after the address clears ack and start.
        apb(1'b1, ibs_pkg::CTRL_OFS, 32'h0000_0001);
        lm.start();
        lm.send_byte(8'hA1, 1'b1);
        lm.send_byte(8'hFF, 1'b0);
        rd(ibs_pkg::STATUS_OFS, 32'h0000_0008);
        // While transmitting, the data line follows the shift latch.
        shift_bit <= 1'b0;
        repeat (2) @(posedge sys_clk);
        chk(32'(sda_out), 32'h0000_0000);
        chk(32'(sda), 32'h0000_0000);
        shift_bit <= 1'b1;
        // A reset in mid-frame clears every flag and releases the data line.
        reset <= 1'b1;
        repeat (2) @(posedge sys_clk);
        reset <= 1'b0;
        rd(ibs_pkg::STATUS_OFS, 32'h0000_0000);
        chk(32'(sda_oe_n), 32'h0000_0001);
        chk(32'(irq), 32'h0000_0000);
        lm.stop();
        // Leave, wait free, lost arbitration and disable while transmitting.
        for (int e = 0; e < 4; e++) begin
            apb(1'b1, ibs_pkg::CTRL_OFS, 32'h0000_0001);
            lm.start();
            lm.send_byte(8'hA1, 1'b1);
            if (e == 2) begin
                @(posedge sys_clk);
                arb_lost <= 1'b1;
            end else begin
                apb(1'b1, ibs_pkg::CTRL_OFS, e == 0 ? 32'h0000_0005 : (e == 1 ? 32'h0000_0009 : 0));
            end
            rd(ibs_pkg::STATUS_OFS, (e == 1 || e == 2) ? 32'h0000_0006 : 0);
            chk(32'(sda_oe_n), 32'h0000_0001);
            arb_lost <= 1'b0;
            lm.stop();
        end
        end_of_test();
    end
endmodule
`default_nettype wire
